// ---- src/dpt_pkg.sv ----
package dpt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PERIOD   = 8'h5c;
  localparam logic [7:0] IDX_SWDELAY  = 8'h5d;
  localparam logic [7:0] IDX_PULSE    = 8'h5e;
  localparam logic [7:0] IDX_TRIM     = 8'h60;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h71;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h72;
  localparam int         ADDR_W       = 10;

  // Field positions
  localparam int SWD_PEAK_BIT   = 7;
  localparam int SWD_POL_BIT    = 5;
  localparam int PER_FIXED_BIT  = 6;
  localparam int TRIM_SYS_BIT   = 6;
  localparam int TRIM_SPEED_BIT = 5;
  localparam int NUM_STEPS      = 5;
  localparam int NUM_EVENTS     = 3;
  localparam int EV_SYS_DONE    = 0;
  localparam int EV_PEAK_DONE   = 1;
  localparam int EV_CLAMP       = 2;

  // Reset values
  localparam logic [7:0] RST_PERIOD  = 8'hff;
  localparam logic [4:0] RST_MIN_OFF = 5'h14;
  localparam logic [4:0] RST_STEPS   = 5'h1f;
  localparam logic [7:0] OFF_BASE    = 8'h04;

  // Timing: the PWM time base and the calibration waits
  localparam int CLK_PS        = 25000;
  localparam int TBASE_PS      = 61035;
  localparam int TICK_CYC      = (TBASE_PS + CLK_PS - 1) / CLK_PS;
  localparam int CLK_KHZ       = 40000;
  localparam int SETTLE_LONG_MS  = 300;
  localparam int SETTLE_SHORT_MS = 30;
  localparam int STEP_MS       = 1;
  localparam int PEAK_MS       = 1;
  localparam int SETTLE_LONG_CYC  = SETTLE_LONG_MS * CLK_KHZ;
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CLK_KHZ;
  localparam int STEP_CYC      = STEP_MS * CLK_KHZ;
  localparam int PEAK_CYC      = PEAK_MS * CLK_KHZ;
  localparam int CNT_W         = 24;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Calibration sequencer
  typedef enum logic [2:0] {
    CS_IDLE   = 3'h1,
    CS_SETTLE = 3'h2,
    CS_STEP   = 3'h4
  } dpt_cal_e;
endpackage : dpt_pkg

// ---- src/dpt_pwm_if.sv ----
`timescale 1ns/1ps
interface dpt_pwm_if;
  logic [7:0] period;
  logic [4:0] min_off;
  logic [7:0] on_req;
  logic       ff_same;
  logic       drive;
  logic       ff;
  logic [7:0] pw;
  logic       clamp;
  modport ctl (output period, min_off, on_req, ff_same,
               input drive, ff, pw, clamp);
  modport gen (input period, min_off, on_req, ff_same,
               output drive, ff, pw, clamp);
endinterface : dpt_pwm_if

// ---- src/dpt_pwm_gen.sv ----
`timescale 1ns/1ps
module dpt_pwm_gen (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Control and results
  dpt_pwm_if.gen   p
);
  logic [1:0] div_q;
  logic [7:0] pos_q, pos_d;
  logic [7:0] on_q, on_d;
  logic [7:0] off_tot, max_on, on_new;
  logic       tick, wrap;
  logic       drive_q, ff_q, clamp_q;
  logic [7:0] pw_q;

  // Cycle bookkeeping in 75 ns ticks of 3 clocks, clamped by the off time
  always_comb begin
    tick    = (div_q == 2'(dpt_pkg::TICK_CYC - 1));
    wrap    = (pos_q >= p.period - 8'h01);
    off_tot = {3'h0, p.min_off} + dpt_pkg::OFF_BASE;
    max_on  = p.period - off_tot;
    on_new  = (p.on_req > max_on) ? max_on : p.on_req;
    pos_d   = wrap ? 8'h00 : pos_q + 8'h01;
    on_d    = wrap ? on_new : on_q;
  end

  // Prescaler: rounds the tick up so off time is never short
  always_ff @(posedge clk_sys) begin
    if (!nrst) div_q <= 2'h0;
    else if (ce) div_q <= tick ? 2'h0 : div_q + 2'h1;
  end

  // Position and latched on time
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pos_q <= 8'h00;
      on_q  <= 8'h00;
    end else if (ce && tick) begin
      pos_q <= pos_d;
      on_q  <= on_d;
    end
  end

  // Drive and feedforward pins, registered
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      drive_q <= 1'b0;
      ff_q    <= ~p.ff_same;
    end else if (ce && tick) begin
      drive_q <= (pos_d < on_d);
      ff_q    <= (pos_d < on_d) ^ ~p.ff_same;
    end
  end

  // Reported width and clamp event, once per PWM cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pw_q    <= 8'h00;
      clamp_q <= 1'b0;
    end else if (ce) begin
      clamp_q <= tick && wrap && (p.on_req > max_on);
      if (tick && wrap) pw_q <= on_new + off_tot;
    end
  end

  assign p.drive = drive_q;
  assign p.ff    = ff_q;
  assign p.pw    = pw_q;
  assign p.clamp = clamp_q;
endmodule : dpt_pwm_gen

// ---- src/dpt_ctrl.sv ----
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dpt_ctrl #(
  parameter int SETTLE_LONG_CYC  = dpt_pkg::SETTLE_LONG_CYC,
  parameter int SETTLE_SHORT_CYC = dpt_pkg::SETTLE_SHORT_CYC,
  parameter int STEP_CYC         = dpt_pkg::STEP_CYC,
  parameter int PEAK_CYC         = dpt_pkg::PEAK_CYC,
  parameter bit FF_SAME_POL      = 1'b0
) (
  // Clock, reset, enable
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  // AXI4-Lite write address and data
  input  wire logic [dpt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [dpt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Converter loop demand, in ticks, from same-clock logic
  input  wire logic [7:0]                duty_request,
  // Converter pins
  output logic                           converter_drive_pin,
  output logic                           feedforward_pin,
  // Calibration activity to the analog trim circuits
  output logic [4:0]                     trim_step_active,
  output logic                           peak_trim_active,
  // Interrupt
  output logic                           irq
);
  dpt_pwm_if pif ();

  // Bus state
  logic                      aw_q, w_q, bvalid_q, rvalid_q;
  logic [dpt_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0]                wdata_q;
  logic                      wstrb_q;
  logic [1:0]                bresp_q, rresp_q;
  logic [7:0]                rdata_q;
  logic                      wr_go, wr_en, rd_go;
  logic [7:0]                wr_idx, rd_idx;
  logic                      wr_hit, rd_hit;
  logic [7:0]                rd_val;

  // Register state
  logic [7:0] period_q;
  logic [4:0] min_off_q;
  logic       peak_q;
  logic [dpt_pkg::CNT_W-1:0] peak_cnt_q;
  logic       sys_cal_q, speedup_q;
  logic [4:0] steps_q;
  dpt_pkg::dpt_cal_e         cal_st_q;
  logic [2:0]                step_idx_q;
  logic [dpt_pkg::CNT_W-1:0] cal_cnt_q;
  logic [dpt_pkg::CNT_W-1:0] settle_lim;
  logic [dpt_pkg::NUM_EVENTS-1:0] ev, stat_q, en_q, clr;
  logic       sys_done, peak_done;

  // Address decode; low two address bits are ignored
  function automatic logic hit(input logic [7:0] idx);
    hit = (idx == dpt_pkg::IDX_PERIOD)   || (idx == dpt_pkg::IDX_SWDELAY)
       || (idx == dpt_pkg::IDX_PULSE)    || (idx == dpt_pkg::IDX_TRIM)
       || (idx == dpt_pkg::IDX_IRQ_STAT) || (idx == dpt_pkg::IDX_IRQ_EN)
       || (idx == dpt_pkg::IDX_IRQ_CLR);
  endfunction : hit

  always_comb begin
    wr_idx = awaddr_q[dpt_pkg::ADDR_W-1:2];
    rd_idx = s_axi_araddr[dpt_pkg::ADDR_W-1:2];
    wr_hit = hit(wr_idx);
    rd_hit = hit(rd_idx);
    wr_go  = ce && aw_q && w_q && !bvalid_q;
    wr_en  = wr_go && wr_hit && wstrb_q;
    rd_go  = s_axi_arvalid && s_axi_arready;
  end

  // Readies drop while frozen so no beat is lost
  assign s_axi_awready = ce && !aw_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = {24'h000000, rdata_q};

  // Write channel: address and data taken in either order
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 8'h00;
      wstrb_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= dpt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? dpt_pkg::RESP_OKAY : dpt_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data; reserved bits are forced to zero
  always_comb begin
    rd_val = 8'h00;
    unique case (rd_idx)
      dpt_pkg::IDX_PERIOD:
        rd_val = period_q | (8'h01 << dpt_pkg::PER_FIXED_BIT);
      dpt_pkg::IDX_SWDELAY:
        rd_val = {peak_q, 1'b0, FF_SAME_POL, min_off_q};
      dpt_pkg::IDX_PULSE:    rd_val = pif.pw;
      dpt_pkg::IDX_TRIM:
        rd_val = {1'b0, sys_cal_q, speedup_q, steps_q};
      dpt_pkg::IDX_IRQ_STAT: rd_val = {5'h00, stat_q};
      dpt_pkg::IDX_IRQ_EN:   rd_val = {5'h00, en_q};
      default:               rd_val = 8'h00;
    endcase
  end

  // Read channel: one outstanding read, answer one cycle later
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      rresp_q  <= dpt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val;
        rresp_q  <= rd_hit ? dpt_pkg::RESP_OKAY : dpt_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Converter timing registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      period_q  <= dpt_pkg::RST_PERIOD;
      min_off_q <= dpt_pkg::RST_MIN_OFF;
    end else if (ce && wr_en) begin
      if (wr_idx == dpt_pkg::IDX_PERIOD)
        period_q <= wdata_q | (8'h01 << dpt_pkg::PER_FIXED_BIT);
      if (wr_idx == dpt_pkg::IDX_SWDELAY)
        min_off_q <= wdata_q[4:0];
    end
  end

  // Peak-current trim; a zero write cannot abort it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      peak_q     <= 1'b0;
      peak_cnt_q <= '0;
    end else if (ce) begin
      if (peak_q) begin
        peak_cnt_q <= peak_cnt_q + 1'b1;
        if (peak_cnt_q == dpt_pkg::CNT_W'(PEAK_CYC - 1))
          peak_q <= 1'b0;
      end else if (wr_en && wr_idx == dpt_pkg::IDX_SWDELAY
                   && wdata_q[dpt_pkg::SWD_PEAK_BIT]) begin
        peak_q     <= 1'b1;
        peak_cnt_q <= '0;
      end
    end
  end

  assign peak_done = ce && peak_q
                  && (peak_cnt_q == dpt_pkg::CNT_W'(PEAK_CYC - 1));

  // Settling wait picked live from the speedup bit
  assign settle_lim = speedup_q ? dpt_pkg::CNT_W'(SETTLE_SHORT_CYC)
                                : dpt_pkg::CNT_W'(SETTLE_LONG_CYC);
  assign sys_done = ce && (cal_st_q == dpt_pkg::CS_STEP)
                 && (step_idx_q == 3'h0)
                 && (!steps_q[0]
                     || cal_cnt_q == dpt_pkg::CNT_W'(STEP_CYC - 1));

  // System calibration: settle, then each enabled step from ring down
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cal_st_q   <= dpt_pkg::CS_IDLE;
      sys_cal_q  <= 1'b0;
      speedup_q  <= 1'b0;
      steps_q    <= dpt_pkg::RST_STEPS;
      step_idx_q <= 3'h0;
      cal_cnt_q  <= '0;
    end else if (ce) begin
      if (wr_en && wr_idx == dpt_pkg::IDX_TRIM)
        speedup_q <= wdata_q[dpt_pkg::TRIM_SPEED_BIT];
      unique case (cal_st_q)
        dpt_pkg::CS_IDLE: begin
          // Step enables stay writable only while the sequencer is idle
          if (wr_en && wr_idx == dpt_pkg::IDX_TRIM) begin
            steps_q <= wdata_q[4:0];
            if (wdata_q[dpt_pkg::TRIM_SYS_BIT]) begin
              sys_cal_q <= 1'b1;
              cal_st_q  <= dpt_pkg::CS_SETTLE;
              cal_cnt_q <= '0;
            end
          end
        end
        dpt_pkg::CS_SETTLE: begin
          cal_cnt_q <= cal_cnt_q + 1'b1;
          if (cal_cnt_q >= settle_lim - 1'b1) begin
            cal_st_q   <= dpt_pkg::CS_STEP;
            step_idx_q <= 3'(dpt_pkg::NUM_STEPS - 1);
            cal_cnt_q  <= '0;
          end
        end
        dpt_pkg::CS_STEP: begin
          cal_cnt_q <= cal_cnt_q + 1'b1;
          if (!steps_q[step_idx_q]
              || cal_cnt_q == dpt_pkg::CNT_W'(STEP_CYC - 1)) begin
            steps_q[step_idx_q] <= 1'b0;
            cal_cnt_q <= '0;
            if (step_idx_q == 3'h0) begin
              cal_st_q  <= dpt_pkg::CS_IDLE;
              sys_cal_q <= 1'b0;
            end else begin
              step_idx_q <= step_idx_q - 3'h1;
            end
          end
        end
      endcase
    end
  end

  // Interrupt events: set wins over a clear in the same cycle
  assign ev[dpt_pkg::EV_SYS_DONE]  = sys_done;
  assign ev[dpt_pkg::EV_PEAK_DONE] = peak_done;
  assign ev[dpt_pkg::EV_CLAMP]     = ce && pif.clamp;
  assign clr = (wr_en && wr_idx == dpt_pkg::IDX_IRQ_CLR)
             ? wdata_q[dpt_pkg::NUM_EVENTS-1:0] : '0;

  for (genvar i = 0; i < dpt_pkg::NUM_EVENTS; i++) begin : g_irq
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        stat_q[i] <= 1'b0;
        en_q[i]   <= 1'b0;
      end else if (ce) begin
        stat_q[i] <= ev[i] || (stat_q[i] && !clr[i]);
        if (wr_en && wr_idx == dpt_pkg::IDX_IRQ_EN)
          en_q[i] <= wdata_q[i];
      end
    end
  end

  assign irq = |(stat_q & en_q);

  // PWM generator hookup
  assign pif.period  = period_q;
  assign pif.min_off = min_off_q;
  assign pif.on_req  = duty_request;
  assign pif.ff_same = FF_SAME_POL;

  dpt_pwm_gen u_pwm (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .p       (pif.gen)
  );

  assign converter_drive_pin = pif.drive;
  assign feedforward_pin     = pif.ff;
  assign peak_trim_active    = peak_q;
  // Only the step under way is flagged to the analog side
  always_comb begin
    trim_step_active = 5'h00;
    if (cal_st_q == dpt_pkg::CS_STEP)
      trim_step_active = steps_q & (5'h01 << step_idx_q);
  end
endmodule : dpt_ctrl

// ---- verification/dpt_ctrl_assertions.sv ----
`timescale 1ns/1ps
module dpt_ctrl_chk #(
  parameter int PEAK_CYC    = 10,
  parameter int STEP_CYC    = 10,
  parameter bit FF_SAME_POL = 1'b0
) (
  // Clock, reset, enable
  input logic        clk_sys,
  input logic        nrst,
  input logic        ce,
  // Register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Converter and trim
  input logic        converter_drive_pin,
  input logic        feedforward_pin,
  input logic [4:0]  trim_step_active,
  input logic        peak_trim_active
);
  logic [9:0] off_q;
  logic [7:0] pk_q;
  logic [7:0] run_q;
  logic [4:0] prv_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Drive low time; starts saturated so leaving reset is no short gap
  always_ff @(posedge clk_sys) begin
    if (!nrst) off_q <= 10'h3ff;
    else if (ce && converter_drive_pin) off_q <= 10'h000;
    else if (ce && off_q != 10'h3ff) off_q <= off_q + 10'h001;
  end

  // Cycles the peak trim has been running
  always_ff @(posedge clk_sys) begin
    if (!nrst) pk_q <= 8'h00;
    else if (ce) pk_q <= peak_trim_active ? pk_q + 8'h01 : 8'h00;
  end

  // Length of the current run of one step pattern
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      run_q <= 8'h00;
      prv_q <= 5'h00;
    end else if (ce) begin
      prv_q <= trim_step_active;
      run_q <= (trim_step_active == prv_q) ? run_q + 8'h01 : 8'h01;
    end
  end

  property p_ff_pol;
    feedforward_pin == (FF_SAME_POL ? converter_drive_pin
                                    : !converter_drive_pin);
  endproperty
  a_ff_pol: assert property (p_ff_pol) else $error("ff level wrong");
  property p_min_off;
    $rose(converter_drive_pin) |-> off_q >= 4 * dpt_pkg::TICK_CYC;
  endproperty
  a_min_off: assert property (p_min_off) else $error("off too short");
  property p_peak_len;
    $fell(peak_trim_active) |-> pk_q == PEAK_CYC;
  endproperty
  a_peak_len: assert property (p_peak_len) else $error("peak len");
  property p_step_len;
    (trim_step_active != prv_q && prv_q != 5'h00) |-> run_q == STEP_CYC;
  endproperty
  a_step_len: assert property (p_step_len) else $error("step len");
  property p_step_one;
    $onehot0(trim_step_active);
  endproperty
  a_step_one: assert property (p_step_one) else $error("two steps");
  property p_rsv_rd;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd) else $error("upper rdata set");
  property p_wr_ans;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_end;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_end: assert property (p_b_end) else $error("bvalid kept");
  property p_ce_hold;
    !ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("ready while frozen");

  // Main scenarios reached
  c_peak: cover property ($fell(peak_trim_active));
  c_ring: cover property (trim_step_active == 5'h10);
  c_ce: cover property (!ce);
endmodule : dpt_ctrl_chk

bind dpt_ctrl dpt_ctrl_chk #(
  .PEAK_CYC(PEAK_CYC), .STEP_CYC(STEP_CYC), .FF_SAME_POL(FF_SAME_POL)
) dpt_ctrl_chk_i (
  .clk_sys, .nrst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .converter_drive_pin, .feedforward_pin, .trim_step_active,
  .peak_trim_active
);

// ---- verification/dpt_ctrl_tb.sv ----
`timescale 1ns/1ps
module dpt_ctrl_tb;
  localparam int         LONG = 200;
  localparam int         SHRT = 20;
  localparam logic [1:0] OK   = dpt_pkg::RESP_OKAY;
  localparam logic [1:0] ER   = dpt_pkg::RESP_SLVERR;
  localparam logic [7:0] PER  = 8'h7f;
  logic        clk_sys, nrst, ce, irq, converter_drive_pin, feedforward_pin;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, peak_trim_active;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  duty_request, d;
  logic [4:0]  trim_step_active, m;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total, n_checks, cyc, on;

  dpt_ctrl #(.SETTLE_LONG_CYC(LONG), .SETTLE_SHORT_CYC(SHRT),
    .STEP_CYC(10), .PEAK_CYC(10), .FF_SAME_POL(1'b0)) dpt_ctrl_i (
    .clk_sys, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .duty_request, .converter_drive_pin, .feedforward_pin,
    .trim_step_active, .peak_trim_active, .irq);

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Write one register; the response is noted for the monitor
  task automatic wr(input logic [7:0] i, input logic [7:0] v,
                    input logic [1:0] r);
    @(posedge clk_sys);
    bq.push_back(r);
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read one register; expected word and response go to the queue
  task automatic rd(input logic [7:0] i, input logic [7:0] v,
                    input logic [1:0] r);
    @(posedge clk_sys);
    rq.push_back({r, 24'h000000, v});
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Measure one full drive cycle, sampled away from the active edge
  task automatic pwm(input int n);
    int hi, lo;
    hi = 0;
    lo = 0;
    @(negedge clk_sys);
    while (converter_drive_pin !== 1'b0) @(negedge clk_sys);
    while (converter_drive_pin !== 1'b1) @(negedge clk_sys);
    while (converter_drive_pin === 1'b1) begin
      hi++;
      @(negedge clk_sys);
    end
    while (converter_drive_pin === 1'b0) begin
      lo++;
      @(negedge clk_sys);
    end
    chk(hi, n * dpt_pkg::TICK_CYC);
    chk(lo, (PER - n) * dpt_pkg::TICK_CYC);
  endtask : pwm

  // One calibration run: settle wait, first step, completion event
  task automatic cal(input logic [7:0] v, input int s, input logic [4:0] f);
    int n;
    n = 0;
    wr(dpt_pkg::IDX_TRIM, v, OK);
    while (trim_step_active === 5'h00 && n < 1000) begin
      n++;
      @(negedge clk_sys);
    end
    chk(n >= s - 4 && n <= s + 4, 1'b1);
    chk(trim_step_active, f);
    rd(dpt_pkg::IDX_TRIM, v, OK);
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      n++;
      @(negedge clk_sys);
    end
    chk(irq, 1'b1);
    rd(dpt_pkg::IDX_TRIM, v & 8'h20, OK);
    wr(dpt_pkg::IDX_IRQ_CLR, 8'h01, OK);
  endtask : cal

  // Monitor: each answer is compared with the oldest note; also a timeout
  always @(posedge clk_sys) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({2'b00, s_axi_rresp, s_axi_rdata}, {2'b00, rq.pop_front()});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk({34'h0, s_axi_bresp}, {34'h0, bq.pop_front()});
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ce} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    duty_request = 8'h00;
    rnd = 32'd70;
    {err_total, n_checks, cyc} = '0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(dpt_pkg::IDX_PULSE, 8'h00, OK);
    rd(dpt_pkg::IDX_SWDELAY, 8'h14, OK);
    rd(dpt_pkg::IDX_PERIOD, 8'hff, OK);
    rd(dpt_pkg::IDX_TRIM, 8'h1f, OK);
    rd(dpt_pkg::IDX_IRQ_STAT, 8'h00, OK);
    wr(8'hff, 8'h55, ER);
    rd(8'hff, 8'h00, ER);
    wr(dpt_pkg::IDX_SWDELAY, 8'hff, OK);
    rd(dpt_pkg::IDX_SWDELAY, 8'h9f, OK);
    repeat (14) @(posedge clk_sys);
    rd(dpt_pkg::IDX_SWDELAY, 8'h1f, OK);
    // A write with its low strobe clear must not start the peak trim
    s_axi_wstrb <= 4'h0;
    wr(dpt_pkg::IDX_SWDELAY, 8'h80, OK);
    s_axi_wstrb <= 4'h1;
    rd(dpt_pkg::IDX_SWDELAY, 8'h1f, OK);
    wr(dpt_pkg::IDX_PERIOD, 8'h3f, OK);
    rd(dpt_pkg::IDX_PERIOD, PER, OK);
    wr(dpt_pkg::IDX_TRIM, 8'h9f, OK);
    rd(dpt_pkg::IDX_TRIM, 8'h1f, OK);
    ce <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    // Two random demands within the limit, then one past it
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      m = rnd[4:0];
      d = (k == 2) ? 8'hff : {2'b00, rnd[13:8]} + 8'h01;
      on = (d > PER - m - 4) ? PER - m - 4 : d;
      wr(dpt_pkg::IDX_SWDELAY, {3'b000, m}, OK);
      duty_request <= d;
      pwm(on);
      rd(dpt_pkg::IDX_PULSE, 8'(on + m + 4), OK);
    end
    rd(dpt_pkg::IDX_IRQ_STAT, 8'h06, OK);
    wr(dpt_pkg::IDX_IRQ_EN, 8'h04, OK);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    wr(dpt_pkg::IDX_IRQ_EN, 8'h00, OK);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    duty_request <= 8'h10;
    repeat (800) @(posedge clk_sys);
    wr(dpt_pkg::IDX_IRQ_CLR, 8'h06, OK);
    rd(dpt_pkg::IDX_IRQ_STAT, 8'h00, OK);
    wr(dpt_pkg::IDX_IRQ_EN, 8'h01, OK);
    cal(8'h5f, LONG, 5'h10);
    cal(8'h62, SHRT, 5'h02);
    end_of_test();
  end
endmodule : dpt_ctrl_tb
